// File: att_defs.vh
// constants for the converter threshold trigger block
`ifndef ATT_DEFS_VH
`define ATT_DEFS_VH

// word indices; byte address is four times the index
`define ATT_IDX_LOWER    6'h18
`define ATT_IDX_UPPER    6'h19
`define ATT_IDX_STATUS   6'h1a

`define ATT_NCH          4
`define ATT_THR_W        12
`define ATT_MODE_W       2
`define ATT_THR_LSB      0
`define ATT_MODE_LSB     12
`define ATT_CH_STRIDE    16

`define ATT_MODE_NEVER   2'h0
`define ATT_MODE_ABOVE   2'h1
`define ATT_MODE_AT_BELOW 2'h2
`define ATT_MODE_UNDEF   2'h3

`define ATT_RESET_WORD   32'h00000000
`define ATT_RESET_MODE   2'h0
`define ATT_RESET_THR    12'h000

`endif

// File: att_chan.v
// one channel comparator: reading against threshold by trigger type
`include "att_defs.vh"

module att_chan (
  input  wire [1:0]  mode,
  input  wire [11:0] threshold,
  input  wire [11:0] reading,
  output reg         hit
);

  always @* begin
    case (mode)
      `ATT_MODE_ABOVE:    hit = (reading > threshold);
      `ATT_MODE_AT_BELOW: hit = (reading <= threshold);
      `ATT_MODE_NEVER:    hit = 1'b0;
      default:            hit = 1'b0;
    endcase
  end

endmodule

// File: att_top.v
// threshold trigger block for four converter channels, apb register slave
// Notes on behaviour
// - two-bit trigger type at bits 13..12 selects channel zero behaviour.
// - type 00 never raises the channel zero trigger.
// - type 01 triggers while reading is strictly above threshold.
// - type 10 triggers while reading is at or below threshold.
// - bits 11..0 hold the twelve-bit channel zero threshold.
// - combined trigger is the OR of all four channel triggers.
// - bits 31..30 of the upper-channel register are reserved.
`include "att_defs.vh"

module att_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [11:0] analog_channel_zero_reading,
  input  wire [11:0] analog_channel_one_reading,
  input  wire [11:0] analog_channel_two_reading,
  input  wire [11:0] analog_channel_three_reading,
  output reg  [3:0]  chan_trigger,
  output reg         combined_trigger
);

  wire [47:0] readings;
  wire [7:0]  modes;
  wire [47:0] thrs;
  wire [3:0]  hits;
  wire [5:0]  word_idx;
  wire        access;
  wire        sel_lower;
  wire        sel_upper;
  wire        sel_status;
  wire        mapped;
  wire        wr_en;
  reg  [31:0] rd_word;

  assign readings = {analog_channel_three_reading,
                     analog_channel_two_reading,
                     analog_channel_one_reading,
                     analog_channel_zero_reading};

  assign word_idx   = paddr[7:2];
  assign access     = psel & penable;
  assign sel_lower  = (word_idx == `ATT_IDX_LOWER);
  assign sel_upper  = (word_idx == `ATT_IDX_UPPER);
  assign sel_status = (word_idx == `ATT_IDX_STATUS);
  assign mapped     = sel_lower | sel_upper | sel_status;
  // write lands only at the edge that completes the access
  assign wr_en      = access & pready & pwrite & (sel_lower | sel_upper);

  ////////////////////////////////////////////////////////////////////////
  // per-channel settings and comparators

  genvar ch;
  generate
    for (ch = 0; ch < `ATT_NCH; ch = ch + 1) begin : g_ch
      localparam [5:0] MY_IDX = (ch < 2) ? `ATT_IDX_LOWER : `ATT_IDX_UPPER;
      localparam integer LANE = (ch % 2) * `ATT_CH_STRIDE;
      reg [1:0]  mode;
      reg [11:0] thr;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode <= `ATT_RESET_MODE;
          thr  <= `ATT_RESET_THR;
        end else if (wr_en && (word_idx == MY_IDX)) begin
          mode <= pwdata[LANE + `ATT_MODE_LSB +: `ATT_MODE_W];
          thr  <= pwdata[LANE + `ATT_THR_LSB +: `ATT_THR_W];
        end
      end

      assign modes[ch*2 +: 2] = mode;
      assign thrs[ch*12 +: 12] = thr;

      att_chan u_chan (
        .mode      (mode),
        .threshold (thr),
        .reading   (readings[ch*12 +: 12]),
        .hit       (hits[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // trigger outputs, registered so they are glitch free at the pins

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_trigger     <= 4'h0;
      combined_trigger <= 1'b0;
    end else begin
      chan_trigger     <= hits;
      combined_trigger <= |hits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits 31..30 and 15..14 read as zero

  always @*begin
    rd_word = `ATT_RESET_WORD;
    if (sel_lower) begin
      rd_word = {2'h0, modes[3:2], thrs[23:12],
                 2'h0, modes[1:0], thrs[11:0]};
    end else if (sel_upper) begin
      rd_word = {2'h0, modes[7:6], thrs[47:36],
                 2'h0, modes[5:4], thrs[35:24]};
    end else if (sel_status) begin
      rd_word = {27'h0, combined_trigger, chan_trigger};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, so every response comes from a flop

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ATT_RESET_WORD;
    end else begin
      pready <= access & ~pready;
      if (access && !pready) begin
        pslverr <= ~mapped;
        prdata  <= (pwrite || !mapped) ? `ATT_RESET_WORD : rd_word;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// File: att_top_monitor.sv
// checker on the ports of the converter threshold trigger block
module att_top_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [3:0] chan_trigger,
  input wire logic       combined_trigger
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_or; combined_trigger == |chan_trigger; endproperty
  a_or: assert property (p_or) else $error("combined not or");
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready off access");
  property p_erq; pslverr |-> pready; endproperty
  a_erq: assert property (p_erq) else $error("error without ready");
  property p_bad; pready && paddr[7:2] > 6'h1a |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped no error");
  property p_map; pready && paddr[7:2] == 6'h18 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped error");
  property p_rst; !$past(presetn) |-> chan_trigger == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("trigger at reset");
endmodule
bind att_top att_top_checker u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .chan_trigger, .combined_trigger);

// File: tb_adc_threshold_trigger.sv
// testbench for the converter threshold trigger block
module tb_adc_threshold_trigger;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, combined_trigger, e;
  logic [3:0]  chan_trigger;
  logic [11:0] r0 = 0, r1 = 0, r2 = 0, r3 = 0;
  int          bad_count = 0, cmp_count = 0;
  // rows: type, threshold, reading, expected channel zero trigger
  logic [26:0] rw [6] = '{{2'h0, 12'h000, 12'hfff, 1'h0},
    {2'h1, 12'h100, 12'h101, 1'h1}, {2'h1, 12'h100, 12'h100, 1'h0},
    {2'h2, 12'h100, 12'h100, 1'h1}, {2'h2, 12'h100, 12'h101, 1'h0},
    {2'h3, 12'h000, 12'hfff, 1'h0}};
  always #25 pclk = ~pclk;
  att_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .analog_channel_zero_reading(r0),
    .analog_channel_one_reading(r1), .analog_channel_two_reading(r2),
    .analog_channel_three_reading(r3), .chan_trigger, .combined_trigger);
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x, input string nm);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  // call just after a rising edge; holds the request until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
    q = prdata; e = pslverr; psel <= 0; penable <= 0;
    // idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
    if (n >= 20) begin bad_count++; end_sim(); end
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(chan_trigger, 4'h0, "reset trig");
    foreach (rw[i]) begin
      apb(1, 8'h60, {18'h0, rw[i][26:13]});
      r0 <= rw[i][12:1];
      repeat (2) @(posedge pclk);
      chk(chan_trigger[0], rw[i][0], "ch0 trig");
      apb(0, 8'h68, 32'h0);
      chk(q[4], rw[i][0], "combined");
    end
    $display("type rows done");
    apb(1, 8'h60, 32'hffffffff);
    apb(0, 8'h60, 32'h0);
    chk(q, 32'h3fff3fff, "lower readback");
    apb(1, 8'h64, 32'hefff0000);
    apb(0, 8'h64, 32'h0);
    chk(q, 32'h2fff0000, "upper readback");
    r3 <= 12'h000;
    repeat (2) @(posedge pclk);
    chk({combined_trigger, chan_trigger}, 5'h18, "ch3 or");
    apb(0, 8'h70, 32'h0);
    chk(e, 1'b1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    apb(1, 8'h60, 32'h10000000);
    r1 <= 12'h001;
    repeat (2) @(posedge pclk);
    chk(chan_trigger, 4'ha, "ch1 trig");
    apb(1, 8'h68, 32'hffffffff);
    apb(0, 8'h60, 32'h0);
    chk(q, 32'h10000000, "status write ignored");
    $display("register tests done");
    presetn <= 0;
    @(posedge pclk);
    chk({combined_trigger, chan_trigger}, 5'h00, "mid reset trig");
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h64, 32'h0);
    chk(q, 32'h0, "reset upper");
    chk({combined_trigger, chan_trigger}, 5'h00, "after reset");
    $display("reset tests done");
    end_sim();
  end
endmodule
